/* fsc_params.svh */
// Constants of the flash status and configuration register block
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH
// Command opcodes
`define FSC_OP_WR_ENABLE   8'h06
`define FSC_OP_WR_DISABLE  8'h04
`define FSC_OP_RD_STAT_LO  8'h05
`define FSC_OP_RD_STAT_HI  8'h35
`define FSC_OP_WR_STAT     8'h01
`define FSC_OP_WR_STAT_HI  8'h31
`define FSC_OP_RD_CFG      8'h15
`define FSC_OP_WR_CFG      8'h11
`define FSC_OP_PROG        8'h02
`define FSC_OP_QPROG       8'h32
`define FSC_OP_PAGE_ER     8'h81
`define FSC_OP_SECT_ER     8'h20
`define FSC_OP_HALF_ER     8'h52
`define FSC_OP_BLOCK_ER    8'hd8
`define FSC_OP_CHIP_ER_A   8'h60
`define FSC_OP_CHIP_ER_B   8'hc7
`define FSC_OP_SUSP_A      8'h75
`define FSC_OP_SUSP_B      8'hb0
`define FSC_OP_RESUME_A    8'h7a
`define FSC_OP_RESUME_B    8'h30
`define FSC_OP_RST_ARM     8'h66
`define FSC_OP_RST_GO      8'h99
`define FSC_OP_DUAL_READ   8'hbb
`define FSC_OP_QUAD_READ   8'heb
// Configuration byte field positions and reset values
`define FSC_CFG_DRV_HI     6
`define FSC_CFG_DRV_LO     5
`define FSC_CFG_WIDE       4
`define FSC_CFG_DUMMY      0
`define FSC_DRV_RESET      2'h3
// Dummy cycle counts after the address
`define FSC_DUMMY_DUAL_0   4'h4
`define FSC_DUMMY_DUAL_1   4'h8
`define FSC_DUMMY_QUAD_0   4'h6
`define FSC_DUMMY_QUAD_1   4'ha
// Status write duration
`define FSC_CLK_PERIOD_NS  8
`define FSC_STAT_WR_NS     5000
`define FSC_STAT_WR_CYC    ((`FSC_STAT_WR_NS + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)
`endif

/* fsc_pkg.sv */
// Types shared by the flash status and configuration register block
package fsc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_ARRAY     = 2'b01,
    ST_SUSPENDED = 2'b11,
    ST_STAT_WR   = 2'b10
  } fsc_state_t;
  typedef enum logic [2:0] {
    OPK_PROG     = 3'h0,
    OPK_PAGE_ER  = 3'h1,
    OPK_SECT_ER  = 3'h2,
    OPK_HALF_ER  = 3'h3,
    OPK_BLOCK_ER = 3'h4,
    OPK_CHIP_ER  = 3'h5
  } fsc_op_t;
endpackage

/* fsc_regs.sv */
// Status and configuration register logic of a serial flash
// Summary of operation
// - Busy flag is 1 while program, erase or status write runs.
// - Write latch visible; without it status writes, program, erase are rejected.
// - Program and erase into the guarded region are blocked.
// - Chip erase runs only when no region is guarded.
// - Block guard changes only while hardware protection is not in force.
// - Guard mode 00 accepts status writes whenever the latch is set.
// - Guard mode 01 refuses status writes while write protect pin is low.
// - Guard mode 01 with pin high accepts status writes with latch set.
// - Guard mode 10 refuses writes until power cycle, which restores 00.
// - Guard mode 11 locks the status word until power cycle, which restores 00.
// - Quad enable takes the protect pin out of use as a control input.
// - Failure flag set on failed, reset-cut or guarded program or erase.
// - Failure flag clears when the next program or erase succeeds.
// - Security lock bits default 0, set singly, then stay 1 until power cycle.
// - Complement bit inverts the region chosen by the block guard.
// - Suspend flag set after a suspend command.
// - Suspend flag cleared by resume, software reset pair, power cycle.
// - Wide page bit defaults 0; 1 selects the 1024 byte buffer.
// - With wide page set, page erase covers the whole 1024 byte page.
// - Two-bit drive field selects output strength, default 11.
// - Dummy bit picks 4/8 dual and 6/10 quad read latency.
// - Quad commands run only while quad enable is set.
`timescale 1ns/10ps
`include "fsc_params.svh"
module fsc_regs #(
  parameter int STAT_WR_CYC = `FSC_STAT_WR_CYC
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             si,
  input  wire logic             wp_n,
  output logic                  so,
  output logic                  so_oe,
  output logic [3:0]            rd_dummy,
  output logic                  rd_quad_ok,
  input  wire logic             op_done,
  input  wire logic             op_fail,
  output logic                  op_start,
  output fsc_pkg::fsc_op_t      op_kind,
  output logic [20:0]           op_addr,
  output logic                  op_quad,
  output logic                  op_wide,
  output logic                  suspend_req,
  output logic                  resume_req,
  output logic                  abort_req,
  output logic                  busy_writing,
  output logic                  write_latch,
  output logic                  write_failure_flag,
  output logic                  quad_io_enable,
  output logic                  output_strength_high,
  output logic                  output_strength_low,
  output logic                  wide_page_select
);
  import fsc_pkg::*;

  // Guarded region of the array: upper or lower part, then complemented
  function automatic logic fsc_prot_hit(input logic [20:0] a,
                                        input logic [4:0]  g,
                                        input logic        c);
    logic [4:0]  e;
    logic [20:0] m;
    logic        h;
    begin
      e = 5'h0;
      m = 21'h0;
      h = 1'b0;
      if (g[2:0] == 3'h0)
        h = 1'b0;
      else if (g[2:1] == 2'h3)
        h = 1'b1;
      else
      begin
        if (!g[4])
          e = 5'hf + {2'h0, g[2:0]};
        else if (g[2])
          e = 5'hf;
        else
          e = 5'hb + {3'h0, g[1:0]};
        m = ~((21'h1 << e) - 21'h1);
        h = g[3] ? ((a & m) == 21'h0) : ((a & m) == m);
      end
      fsc_prot_hit = h ^ c;
    end
  endfunction

  // ---------------- Link side, on the serial clock ----------------
  logic [7:0]  lk_shift;
  logic [2:0]  lk_bit;
  logic        lk_first;
  logic [2:0]  lk_bytes;
  logic        lk_aligned;
  logic [7:0]  lk_opcode;
  logic [23:0] lk_addr;
  logic [7:0]  lk_out;
  logic        lk_rd;
  logic [15:0] snap_stat;
  logic [7:0]  snap_cfg;
  logic [7:0]  lk_byte_in;
  assign lk_byte_in = {lk_shift[6:0], si};

  // Bit position restarts with every frame; chip select ends the frame
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      lk_bit   <= 3'h0;
      lk_first <= 1'b1;
    end
    else
    begin
      lk_bit   <= lk_bit + 3'h1;
      lk_first <= 1'b0;
    end
  end

  // Opcode, address and data bytes are held past the frame end so the
  // core can take them once it sees chip select high and stable
  always_ff @(posedge sclk)
  begin
    lk_shift   <= lk_byte_in;
    lk_aligned <= (lk_bit == 3'h7);
    if (lk_first)
      lk_bytes <= 3'h0;
    if (lk_bit == 3'h7)
    begin
      if (lk_first || lk_bytes == 3'h0)
        lk_opcode <= lk_byte_in;
      else if (lk_bytes < 3'h4)
        lk_addr <= {lk_addr[15:0], lk_byte_in};
      if (!lk_first && lk_bytes != 3'h7)
        lk_bytes <= lk_bytes + 3'h1;
      else if (lk_first)
        lk_bytes <= 3'h1;
    end
  end

  // Read data byte; the snapshot is frozen for the whole frame
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      lk_rd      <= 1'b0;
      lk_out     <= 8'h0;
      rd_dummy   <= 4'h0;
      rd_quad_ok <= 1'b0;
    end
    else if (lk_bit == 3'h7 && (lk_first || lk_bytes == 3'h0))
    begin
      lk_rd <= (lk_byte_in == `FSC_OP_RD_STAT_LO) ||
               (lk_byte_in == `FSC_OP_RD_STAT_HI) ||
               (lk_byte_in == `FSC_OP_RD_CFG);
      if (lk_byte_in == `FSC_OP_RD_STAT_HI)
        lk_out <= snap_stat[15:8];
      else if (lk_byte_in == `FSC_OP_RD_CFG)
        lk_out <= snap_cfg;
      else
        lk_out <= snap_stat[7:0];
      // Latency after the address for the multi-line reads
      if (lk_byte_in == `FSC_OP_DUAL_READ)
        rd_dummy <= snap_cfg[`FSC_CFG_DUMMY] ? `FSC_DUMMY_DUAL_1
                                             : `FSC_DUMMY_DUAL_0;
      else if (lk_byte_in == `FSC_OP_QUAD_READ && snap_stat[9])
      begin
        rd_dummy   <= snap_cfg[`FSC_CFG_DUMMY] ? `FSC_DUMMY_QUAD_1
                                               : `FSC_DUMMY_QUAD_0;
        rd_quad_ok <= 1'b1;
      end
    end
  end

  // Output bits leave on the falling edge, most significant first
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      so    <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      so    <= lk_out[3'h7 - lk_bit];
      so_oe <= lk_rd;
    end
  end

  // ---------------- Core side, on clk ----------------
  logic [1:0] pin_raw;
  logic [1:0] sy1;
  logic [1:0] sy2;
  logic [1:0] sy3;
  logic [1:0] pin_stable;
  assign pin_raw = {wp_n, cs_n};

  // Three-stage pin filter: a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          sy1[gi]        <= 1'b1;
          sy2[gi]        <= 1'b1;
          sy3[gi]        <= 1'b1;
          pin_stable[gi] <= 1'b1;
        end
        else
        begin
          sy1[gi] <= pin_raw[gi];
          sy2[gi] <= sy1[gi];
          sy3[gi] <= sy2[gi];
          if (sy2[gi] == sy3[gi])
            pin_stable[gi] <= sy3[gi];
        end
      end
    end
  endgenerate

  logic        cs_prev;
  logic        frame_end;
  fsc_state_t  state;
  fsc_state_t  next_state;
  logic [9:0]  stat_timer;
  logic [4:0]  block_guard;
  logic        status_guard_mode_low;
  logic        status_guard_mode_high;
  logic        protect_complement;
  logic [2:0]  security_lock;
  logic        suspend_flag;
  logic        dummy_cycle_select;
  logic        rst_armed;
  logic        op_is_arr;
  logic        op_is_chip;
  logic        guard_ok;
  logic        hw_protect;
  logic        none_sel;
  logic        cmd_go;
  logic        wrsr_go;
  logic        cfg_go;
  logic        arr_go;
  logic        arr_prot;
  logic        sw_reset;
  logic [7:0]  lo_byte;
  logic [7:0]  hi_byte;

  always_ff @(posedge clk)
  begin
    if (srst)
      cs_prev <= 1'b1;
    else
      cs_prev <= pin_stable[0];
  end
  assign frame_end = pin_stable[0] & ~cs_prev;

  // Only whole bytes count as a command
  assign cmd_go     = frame_end && lk_aligned && lk_bytes != 3'h0;
  assign op_is_chip = lk_opcode == `FSC_OP_CHIP_ER_A ||
                      lk_opcode == `FSC_OP_CHIP_ER_B;
  assign op_is_arr  = lk_opcode == `FSC_OP_PROG    ||
                      (lk_opcode == `FSC_OP_QPROG && quad_io_enable) ||
                      lk_opcode == `FSC_OP_PAGE_ER ||
                      lk_opcode == `FSC_OP_SECT_ER ||
                      lk_opcode == `FSC_OP_HALF_ER ||
                      lk_opcode == `FSC_OP_BLOCK_ER;
  // Protect pin is lost as a control input while quad lines are on
  assign hw_protect = !status_guard_mode_high && status_guard_mode_low &&
                      !pin_stable[1] && !quad_io_enable;
  always_comb
  begin
    case ({status_guard_mode_high, status_guard_mode_low})
      2'b00:   guard_ok = 1'b1;
      2'b01:   guard_ok = !hw_protect;
      default: guard_ok = 1'b0;
    endcase
  end
  assign wrsr_go = cmd_go && write_latch && state == ST_IDLE && guard_ok &&
                   lk_bytes >= 3'h2 &&
                   (lk_opcode == `FSC_OP_WR_STAT ||
                    lk_opcode == `FSC_OP_WR_STAT_HI);
  assign cfg_go  = cmd_go && write_latch && state == ST_IDLE &&
                   lk_opcode == `FSC_OP_WR_CFG && lk_bytes >= 3'h2;
  assign arr_go  = cmd_go && write_latch && state == ST_IDLE &&
                   ((op_is_arr && lk_bytes >= 3'h4) || op_is_chip);
  assign none_sel = protect_complement ? (block_guard[2:1] == 2'h3)
                                       : (block_guard[2:0] == 3'h0);
  assign arr_prot = op_is_chip ? !none_sel
                  : fsc_prot_hit(lk_addr[20:0], block_guard,
                                 protect_complement);
  assign sw_reset = cmd_go && rst_armed && lk_opcode == `FSC_OP_RST_GO;
  // The last byte shifted in sits at the low end, so the first data byte
  // moves up by one byte lane for every further byte in the frame
  assign lo_byte  = (lk_bytes == 3'h2) ? lk_addr[7:0]
                  : (lk_bytes == 3'h3) ? lk_addr[15:8] : lk_addr[23:16];
  assign hi_byte  = (lk_opcode == `FSC_OP_WR_STAT_HI) ? lo_byte
                  : (lk_bytes == 3'h3) ? lk_addr[7:0] : lk_addr[15:8];

  // Operation sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (wrsr_go)
          next_state = ST_STAT_WR;
        else if (arr_go && !arr_prot)
          next_state = ST_ARRAY;
      ST_STAT_WR:
        if (stat_timer == 10'h0)
          next_state = ST_IDLE;
      ST_ARRAY:
        if (sw_reset || op_done)
          next_state = ST_IDLE;
        else if (cmd_go && (lk_opcode == `FSC_OP_SUSP_A ||
                            lk_opcode == `FSC_OP_SUSP_B))
          next_state = ST_SUSPENDED;
      ST_SUSPENDED:
        if (sw_reset)
          next_state = ST_IDLE;
        else if (cmd_go && (lk_opcode == `FSC_OP_RESUME_A ||
                            lk_opcode == `FSC_OP_RESUME_B))
          next_state = ST_ARRAY;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state        <= ST_IDLE;
      busy_writing <= 1'b0;
      stat_timer   <= 10'h0;
    end
    else
    begin
      state        <= next_state;
      busy_writing <= next_state == ST_STAT_WR ||
                      next_state == ST_ARRAY;
      if (state == ST_IDLE && wrsr_go)
        stat_timer <= 10'(STAT_WR_CYC - 1);
      else if (stat_timer != 10'h0)
        stat_timer <= stat_timer - 10'h1;
    end
  end

  // Requests to the array engine, one-cycle pulses
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      op_start    <= 1'b0;
      op_kind     <= OPK_PROG;
      op_addr     <= 21'h0;
      op_quad     <= 1'b0;
      op_wide     <= 1'b0;
      suspend_req <= 1'b0;
      resume_req  <= 1'b0;
      abort_req   <= 1'b0;
    end
    else
    begin
      op_start    <= state == ST_IDLE && next_state == ST_ARRAY;
      suspend_req <= state == ST_ARRAY && next_state == ST_SUSPENDED;
      resume_req  <= state == ST_SUSPENDED && next_state == ST_ARRAY;
      abort_req   <= sw_reset && state != ST_IDLE && state != ST_STAT_WR;
      if (state == ST_IDLE && next_state == ST_ARRAY)
      begin
        op_addr <= lk_addr[20:0];
        op_quad <= lk_opcode == `FSC_OP_QPROG;
        op_wide <= wide_page_select;
        if (op_is_chip)
          op_kind <= OPK_CHIP_ER;
        else if (lk_opcode == `FSC_OP_PAGE_ER)
          op_kind <= OPK_PAGE_ER;
        else if (lk_opcode == `FSC_OP_SECT_ER)
          op_kind <= OPK_SECT_ER;
        else if (lk_opcode == `FSC_OP_HALF_ER)
          op_kind <= OPK_HALF_ER;
        else if (lk_opcode == `FSC_OP_BLOCK_ER)
          op_kind <= OPK_BLOCK_ER;
        else
          op_kind <= OPK_PROG;
      end
    end
  end

  // Write latch and software reset pairing
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      write_latch <= 1'b0;
      rst_armed   <= 1'b0;
    end
    else
    begin
      if (cmd_go)
        rst_armed <= lk_opcode == `FSC_OP_RST_ARM;
      if (cmd_go && lk_opcode == `FSC_OP_WR_ENABLE)
        write_latch <= 1'b1;
      else if (sw_reset || wrsr_go || cfg_go || arr_go ||
               (cmd_go && lk_opcode == `FSC_OP_WR_DISABLE))
        write_latch <= 1'b0;
    end
  end

  // Status word fields; power-up reset restores guard mode 00
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      block_guard            <= 5'h0;
      status_guard_mode_low  <= 1'b0;
      status_guard_mode_high <= 1'b0;
      quad_io_enable         <= 1'b0;
      security_lock          <= 3'h0;
      protect_complement     <= 1'b0;
    end
    else if (wrsr_go)
    begin
      if (lk_opcode == `FSC_OP_WR_STAT && !hw_protect)
      begin
        block_guard           <= lo_byte[6:2];
        status_guard_mode_low <= lo_byte[7];
      end
      if (lk_opcode == `FSC_OP_WR_STAT_HI || lk_bytes >= 3'h3)
      begin
        status_guard_mode_high <= hi_byte[0];
        quad_io_enable         <= hi_byte[1];
        security_lock          <= security_lock | hi_byte[5:3];
        protect_complement     <= hi_byte[6];
      end
    end
  end

  // Failure flag: a new failure beats the clear from a success
  always_ff @(posedge clk)
  begin
    if (srst)
      write_failure_flag <= 1'b0;
    else if ((arr_go && arr_prot) || (op_done && op_fail) ||
             (sw_reset && (state == ST_ARRAY || state == ST_SUSPENDED)))
      write_failure_flag <= 1'b1;
    else if (op_done && state == ST_ARRAY)
      write_failure_flag <= 1'b0;
  end

  // Suspend flag
  always_ff @(posedge clk)
  begin
    if (srst)
      suspend_flag <= 1'b0;
    else if (state == ST_ARRAY && next_state == ST_SUSPENDED)
      suspend_flag <= 1'b1;
    else if (state == ST_SUSPENDED && next_state != ST_SUSPENDED)
      suspend_flag <= 1'b0;
  end

  // Configuration byte; reserved bits are dropped on write
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {output_strength_high, output_strength_low} <= `FSC_DRV_RESET;
      wide_page_select   <= 1'b0;
      dummy_cycle_select <= 1'b0;
    end
    else if (cfg_go)
    begin
      output_strength_high <= lo_byte[`FSC_CFG_DRV_HI];
      output_strength_low  <= lo_byte[`FSC_CFG_DRV_LO];
      wide_page_select     <= lo_byte[`FSC_CFG_WIDE];
      dummy_cycle_select   <= lo_byte[`FSC_CFG_DUMMY];
    end
  end

  // Snapshot for the link; held still while chip select is low, so a
  // poll inside one frame sees the value from before that frame
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      snap_stat <= 16'h0;
      snap_cfg  <= 8'h0;
    end
    else if (pin_stable[0] && sy3[0])
    begin
      snap_stat <= {suspend_flag, protect_complement, security_lock,
                    write_failure_flag, quad_io_enable,
                    status_guard_mode_high, status_guard_mode_low,
                    block_guard, write_latch, busy_writing};
      snap_cfg  <= {1'b0, output_strength_high, output_strength_low,
                    wide_page_select, 3'h0, dummy_cycle_select};
    end
  end

  // Checks
  busy_match_a: assert property (@(posedge clk) disable iff (srst)
    busy_writing == (state == ST_STAT_WR || state == ST_ARRAY))
    else $error("busy flag disagrees with operation state");
  stat_time_a: assert property (@(posedge clk) disable iff (srst)
    $rose(state == ST_STAT_WR) |-> (state == ST_STAT_WR) [*8])
    else $error("status write ended too early");
  latch_gate_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_go && !write_latch && state == ST_IDLE)
    |=> !op_start && state == ST_IDLE)
    else $error("command accepted without write latch");
  region_block_a: assert property (@(posedge clk) disable iff (srst)
    (arr_go && arr_prot) |=> !op_start ##0 write_failure_flag)
    else $error("guarded region not blocked");
  chip_none_a: assert property (@(posedge clk) disable iff (srst)
    (arr_go && op_is_chip && !none_sel) |=> state == ST_IDLE)
    else $error("chip erase ran with region guarded");
  hw_hold_a: assert property (@(posedge clk) disable iff (srst)
    hw_protect |=> $stable(block_guard))
    else $error("block guard changed under hardware protection");
  lockdown_a: assert property (@(posedge clk) disable iff (srst)
    status_guard_mode_high |=> $stable({status_guard_mode_low,
                                        quad_io_enable, block_guard}))
    else $error("status word changed while locked");
  locks_sticky_a: assert property (@(posedge clk) disable iff (srst)
    ##1 ((security_lock & $past(security_lock)) == $past(security_lock)))
    else $error("security lock bit cleared");
  fail_clear_a: assert property (@(posedge clk) disable iff (srst)
    (op_done && !op_fail && state == ST_ARRAY && !sw_reset)
    |=> !write_failure_flag)
    else $error("failure flag not cleared after success");
  suspend_set_a: assert property (@(posedge clk) disable iff (srst)
    suspend_req |-> suspend_flag)
    else $error("suspend flag not set on suspend");
endmodule

/* fsc_host_model.sv */
// Serial host model that issues command frames to the register block
`timescale 1ns/10ps
module fsc_host_model (
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  // Sends n bytes from the top of tx MSB first; rx keeps the last byte.
  // Link clock runs only inside the frame; si toggles outside it so a
  // stale bit never looks like valid data
  task automatic frame(input logic [31:0] tx, input int n,
                       output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    #20;
    for (int i = 31; i > 31 - 8 * n; i--)
    begin
      si = tx[i];
      #24 rx = {rx[6:0], so};
      sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    #20 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

/* fsc_regs_bench.sv */
// Self-checking bench of the status and configuration register block
`timescale 1ns/10ps
module fsc_regs_bench;
  import fsc_pkg::*;
  localparam int WR_CYC = 16;
  logic        clk = 1'b0;
  logic        srst, sclk, cs_n, si, so, wp_n, op_done, op_fail;
  logic        op_start, busy, latch, fail, s_hi, s_lo, wide;
  logic        abrt, wide_op, qok, qk, qe;
  logic [3:0]  dummy, dmy;
  int          aborts = 0;
  fsc_op_t     op_kind;
  logic [20:0] op_addr;
  logic [7:0]  rx;
  int          fail_count = 0, total_checks = 0, starts = 0, n;

  // Core clock and a count of array starts, since the pulse is short
  always #4 clk = ~clk;
  always @(posedge clk) if (op_start === 1'b1) starts <= starts + 1;
  always @(posedge clk) if (abrt === 1'b1) aborts <= aborts + 1;
  // Read setup stands only inside a frame, so catch it on the link clock
  always @(negedge sclk)
    if (cs_n === 1'b0)
    begin
      dmy <= dummy;
      qk  <= qok;
    end

  fsc_host_model u_fsc_host_model (.cs_n(cs_n), .sclk(sclk), .si(si),
    .so(so));
  fsc_regs #(.STAT_WR_CYC(WR_CYC)) u_fsc_regs (.clk(clk), .srst(srst),
    .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(),
    .rd_dummy(dummy), .rd_quad_ok(qok), .op_done(op_done),
    .op_fail(op_fail), .op_start(op_start), .op_kind(op_kind),
    .op_addr(op_addr), .op_quad(), .op_wide(wide_op), .suspend_req(),
    .resume_req(), .abort_req(abrt), .busy_writing(busy),
    .write_latch(latch), .write_failure_flag(fail), .quad_io_enable(qe),
    .output_strength_high(s_hi), .output_strength_low(s_lo),
    .wide_page_select(wide));

  // Comparison, counted either way
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One frame, then a gap long enough for decode and the idle time
  task automatic wr(input logic [31:0] tx, input int nb);
    u_fsc_host_model.frame(tx, nb, rx);
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic wen;
    wr({8'h06, 24'h0}, 1);
  endtask
  task automatic rchk(input string nm, input logic [7:0] op, exp);
    wr({op, 24'h0}, 2);
    chk(nm, rx, exp);
  endtask
  // Accepted status write: busy must stand for the whole write time
  task automatic swr(input logic [31:0] tx, input int nb);
    u_fsc_host_model.frame(tx, nb, rx);
    n = 0;
    repeat (WR_CYC + 16)
    begin
      @(posedge clk);
      #1;
      if (busy === 1'b1) n++;
    end
    chk("busy cycles", n, WR_CYC);
  endtask

  // Main sequence
  initial
  begin
    srst = 1'b1;
    wp_n = 1'b1;
    op_done = 1'b0;
    op_fail = 1'b0;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    repeat (6) @(posedge clk);
    rchk("stat_lo", 8'h05, 8'h00);
    rchk("stat_hi", 8'h35, 8'h00);
    rchk("config", 8'h15, 8'h60);
    wr({8'h01, 8'h1c, 16'h0}, 2);
    rchk("stat_lo", 8'h05, 8'h00);
    $display("test reset done");
    wen();
    chk("latch", latch, 1'b1);
    swr({8'h01, 8'h1c, 16'h0}, 2);
    rchk("stat_lo", 8'h05, 8'h1c);
    wen();
    wr({8'h02, 24'h0a0000}, 4);
    chk("starts", starts, 0);
    chk("fail", fail, 1'b1);
    wen();
    wr({8'hc7, 24'h0}, 1);
    chk("starts", starts, 0);
    $display("test guard done");
    wen();
    swr({8'h01, 8'h00, 16'h0}, 2);
    wen();
    wr({8'h02, 24'h0abcde}, 4);
    chk("starts", starts, 1);
    chk("kind", op_kind, OPK_PROG);
    chk("addr", op_addr, 21'h0abcde);
    chk("busy", busy, 1'b1);
    wr({8'h75, 24'h0}, 1);
    rchk("stat_hi", 8'h35, 8'h84);
    wr({8'h7a, 24'h0}, 1);
    rchk("stat_hi", 8'h35, 8'h04);
    op_done = 1'b1;
    @(posedge clk);
    #1 op_done = 1'b0;
    repeat (3) @(posedge clk);
    chk("fail", fail, 1'b0);
    chk("busy", busy, 1'b0);
    $display("test program done");
    wen();
    wr({8'h11, 8'hff, 16'h0}, 2);
    rchk("config", 8'h15, 8'h71);
    chk("wide", wide, 1'b1);
    wr({8'hbb, 24'h0}, 1);
    chk("dummy", dmy, 4'h8);
    wen();
    wr({8'h81, 24'h000400}, 4);
    chk("wide op", wide_op, 1'b1);
    chk("kind", op_kind, OPK_PAGE_ER);
    wr({8'h75, 24'h0}, 1);
    wr({8'h66, 24'h0}, 1);
    wr({8'h99, 24'h0}, 1);
    rchk("stat_hi", 8'h35, 8'h04);
    chk("aborts", aborts, 1);
    wen();
    wr({8'h11, 24'h0}, 2);
    rchk("config", 8'h15, 8'h00);
    chk("drive", {s_hi, s_lo}, 2'b00);
    wr({8'hbb, 24'h0}, 1);
    chk("dummy", dmy, 4'h4);
    wr({8'heb, 24'h0}, 1);
    chk("quad read", {qk, dmy}, 5'h00);
    wen();
    swr({8'h31, 8'h02, 16'h0}, 2);
    chk("quad enable", qe, 1'b1);
    wr({8'heb, 24'h0}, 1);
    chk("quad read", {qk, dmy}, 5'h16);
    wen();
    swr({8'h31, 8'h00, 16'h0}, 2);
    $display("test config done");
    wen();
    swr({8'h01, 8'h80, 16'h0}, 2);
    wp_n = 1'b0;
    wen();
    wr({8'h01, 8'h84, 16'h0}, 2);
    wr({8'h04, 24'h0}, 1);
    rchk("stat_lo", 8'h05, 8'h80);
    wp_n = 1'b1;
    wen();
    swr({8'h01, 8'h04, 8'h01, 8'h0}, 3);
    wen();
    wr({8'h01, 8'h1c, 16'h0}, 2);
    wr({8'h04, 24'h0}, 1);
    rchk("stat_lo", 8'h05, 8'h04);
    srst = 1'b1;
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    repeat (6) @(posedge clk);
    rchk("stat_hi", 8'h35, 8'h00);
    wen();
    swr({8'h01, 8'h00, 8'h40, 8'h0}, 3);
    wen();
    wr({8'h02, 24'h000100}, 4);
    chk("starts", starts, 2);
    chk("fail", fail, 1'b1);
    wen();
    swr({8'h01, 8'h80, 8'h01, 8'h0}, 3);
    wen();
    wr({8'h01, 8'h1c, 16'h0}, 2);
    wr({8'h04, 24'h0}, 1);
    rchk("stat_lo", 8'h05, 8'h80);
    $display("test guard modes done");
    stop_test();
  end
endmodule
